// ===== core/acl_clock_link_top.sv
/*
 * acl_clock_link_top: per-core link control registers on AXI4-Lite plus the
 * clock routing for ports A/B (core 0) and C/D (core 1).
 * Assumes: one 40 MHz clock, asynchronous active-high reset, a well-behaved
 * AXI4-Lite master with at most one write and one read under way, and pad
 * inputs that show the resolved pin level.
 */
// Local design decisions: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
module acl_clock_link_top (
	input wire logic clk_in, // 40 MHz system clock
	input wire logic rst_in, // asynchronous reset, active high
	input wire logic [3:0] s_axi_awaddr_in, // write address
	input wire logic s_axi_awvalid_in, // write address valid
	output logic s_axi_awready_out, // write address ready
	input wire logic [31:0] s_axi_wdata_in, // write data
	input wire logic [3:0] s_axi_wstrb_in, // write byte strobes
	input wire logic s_axi_wvalid_in, // write data valid
	output logic s_axi_wready_out, // write data ready
	output logic [1:0] s_axi_bresp_out, // write response
	output logic s_axi_bvalid_out, // write response valid
	input wire logic s_axi_bready_in, // write response ready
	input wire logic [3:0] s_axi_araddr_in, // read address
	input wire logic s_axi_arvalid_in, // read address valid
	output logic s_axi_arready_out, // read address ready
	output logic [31:0] s_axi_rdata_out, // read data
	output logic [1:0] s_axi_rresp_out, // read response
	output logic s_axi_rvalid_out, // read data valid
	input wire logic s_axi_rready_in, // read data ready
	input wire logic [5:0] port_a_drive_in, // port A clock values
	input wire logic [5:0] port_a_dir_in, // port A output enables
	output logic [5:0] port_a_clk_out, // clocks into port A
	input wire logic [5:0] port_b_drive_in, // port B clock values
	input wire logic [5:0] port_b_dir_in, // port B output enables
	output logic [5:0] port_b_clk_out, // clocks into port B
	input wire logic [5:0] port_c_drive_in, // port C clock values
	input wire logic [5:0] port_c_dir_in, // port C output enables
	output logic [5:0] port_c_clk_out, // clocks into port C
	input wire logic [5:0] port_d_drive_in, // port D clock values
	input wire logic [5:0] port_d_dir_in, // port D output enables
	output logic [5:0] port_d_clk_out, // clocks into port D
	input wire logic [5:0] pad_a_in, // port A pin levels
	output logic [5:0] pad_a_out, // port A pin drive
	output logic [5:0] pad_a_oe_out, // port A pin enables
	input wire logic [5:0] pad_b_in, // port B pin levels
	output logic [5:0] pad_b_out, // port B pin drive
	output logic [5:0] pad_b_oe_out, // port B pin enables
	input wire logic [5:0] pad_c_in, // port C pin levels
	output logic [5:0] pad_c_out, // port C pin drive
	output logic [5:0] pad_c_oe_out, // port C pin enables
	input wire logic [5:0] pad_d_in, // port D pin levels
	output logic [5:0] pad_d_out, // port D pin drive
	output logic [5:0] pad_d_oe_out // port D pin enables
);
	// ==========================================================================
	// storage
	// ==========================================================================
	logic [11:0] clock_link_control_reg; // core 0 codes, A/B pair
	logic [11:0] clock_link_control_reg_core1; // core 1 codes, C/D pair
	logic aw_held; // write address taken, waiting for data
	logic w_held; // write data taken, waiting for address
	logic [3:0] aw_addr; // captured write address
	logic [31:0] w_data; // captured write data
	logic [3:0] w_strb; // captured strobes
	logic write_fire; // both halves present, perform the write
	logic [11:0] lane_mask; // implemented bits enabled by the strobes
	logic [11:0] next_merged; // strobe-merged value for the addressed register
	logic wr_core0; // write hits core 0 register
	logic wr_core1; // write hits core 1 register

	// ==========================================================================
	// write decode
	// ==========================================================================
	// low byte lane carries bits 7-0, next lane bits 11-8
	assign lane_mask = {{4{w_strb[1]}}, {8{w_strb[0]}}};
	assign write_fire = aw_held && w_held && !s_axi_bvalid_out;
	assign wr_core0 = write_fire && (aw_addr == acl_pkg::CORE0_LINK_OFFSET);
	assign wr_core1 = write_fire && (aw_addr == acl_pkg::CORE1_LINK_OFFSET);
	always_comb begin
		// merge is taken from whichever register the address selects
		if (aw_addr == acl_pkg::CORE1_LINK_OFFSET) begin
			next_merged = (clock_link_control_reg_core1 & ~lane_mask) |
				(w_data[11:0] & lane_mask);
		end else begin
			next_merged = (clock_link_control_reg & ~lane_mask) |
				(w_data[11:0] & lane_mask);
		end
	end

	// ==========================================================================
	// write channels: address and data taken in either order
	// ==========================================================================
	// readies drop once a half is held, so a second write waits for the response
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= 4'h0;
			w_data <= 32'h0000_0000;
			w_strb <= 4'h0;
			s_axi_awready_out <= 1'b1;
			s_axi_wready_out <= 1'b1;
			s_axi_bvalid_out <= 1'b0;
			s_axi_bresp_out <= acl_pkg::RESP_OKAY;
		end else begin
			if (s_axi_awvalid_in && s_axi_awready_out) begin
				// capture the address half
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr_in;
				s_axi_awready_out <= 1'b0;
			end
			if (s_axi_wvalid_in && s_axi_wready_out) begin
				// capture the data half
				w_held <= 1'b1;
				w_data <= s_axi_wdata_in;
				w_strb <= s_axi_wstrb_in;
				s_axi_wready_out <= 1'b0;
			end
			if (write_fire) begin
				// unmapped addresses change nothing and answer with an error
				aw_held <= 1'b0;
				w_held <= 1'b0;
				s_axi_bvalid_out <= 1'b1;
				s_axi_bresp_out <= (wr_core0 || wr_core1) ? acl_pkg::RESP_OKAY :
					acl_pkg::RESP_SLVERR;
			end
			if (s_axi_bvalid_out && s_axi_bready_in) begin
				// response taken, reopen both channels
				s_axi_bvalid_out <= 1'b0;
				s_axi_awready_out <= 1'b1;
				s_axi_wready_out <= 1'b1;
			end
		end
	end

	// ==========================================================================
	// link control registers, one per core
	// ==========================================================================
	// hardware reset leaves every pair unlinked
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			clock_link_control_reg <= acl_pkg::LINK_REG_RESET;
			clock_link_control_reg_core1 <= acl_pkg::LINK_REG_RESET;
		end else begin
			// each core's register is reached only at its own offset
			if (wr_core0) begin
				clock_link_control_reg <= next_merged;
			end
			if (wr_core1) begin
				clock_link_control_reg_core1 <= next_merged;
			end
		end
	end

	// ==========================================================================
	// read channel
	// ==========================================================================
	// reserved bits 31-12 read as zero
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			s_axi_arready_out <= 1'b1;
			s_axi_rvalid_out <= 1'b0;
			s_axi_rdata_out <= 32'h0000_0000;
			s_axi_rresp_out <= acl_pkg::RESP_OKAY;
		end else begin
			if (s_axi_arvalid_in && s_axi_arready_out) begin
				s_axi_arready_out <= 1'b0;
				s_axi_rvalid_out <= 1'b1;
				if (s_axi_araddr_in == acl_pkg::CORE0_LINK_OFFSET) begin
					s_axi_rdata_out <= {20'h0_0000, clock_link_control_reg};
					s_axi_rresp_out <= acl_pkg::RESP_OKAY;
				end else if (s_axi_araddr_in == acl_pkg::CORE1_LINK_OFFSET) begin
					s_axi_rdata_out <= {20'h0_0000, clock_link_control_reg_core1};
					s_axi_rresp_out <= acl_pkg::RESP_OKAY;
				end else begin
					// unmapped: zero data with an error answer
					s_axi_rdata_out <= 32'h0000_0000;
					s_axi_rresp_out <= acl_pkg::RESP_SLVERR;
				end
			end
			if (s_axi_rvalid_out && s_axi_rready_in) begin
				s_axi_rvalid_out <= 1'b0;
				s_axi_arready_out <= 1'b1;
			end
		end
	end

	// ==========================================================================
	// clock routing; the pin paths stay combinational, trading the registered
	// output style for zero added clock latency
	// ==========================================================================
	// A/B: shared pin is port A's
	acl_pair_mux #(
		.SHARE_ON_SECOND(1'b0)
	) u_mux_ab (
		.code_in(clock_link_control_reg),
		.first_drive_in(port_a_drive_in),
		.first_dir_in(port_a_dir_in),
		.first_clk_out(port_a_clk_out),
		.second_drive_in(port_b_drive_in),
		.second_dir_in(port_b_dir_in),
		.second_clk_out(port_b_clk_out),
		.pad1_in(pad_a_in),
		.pad1_out(pad_a_out),
		.pad1_oe_out(pad_a_oe_out),
		.pad2_in(pad_b_in),
		.pad2_out(pad_b_out),
		.pad2_oe_out(pad_b_oe_out)
	);

	// C/D: shared pin is port D's
	acl_pair_mux #(
		.SHARE_ON_SECOND(1'b1)
	) u_mux_cd (
		.code_in(clock_link_control_reg_core1),
		.first_drive_in(port_c_drive_in),
		.first_dir_in(port_c_dir_in),
		.first_clk_out(port_c_clk_out),
		.second_drive_in(port_d_drive_in),
		.second_dir_in(port_d_dir_in),
		.second_clk_out(port_d_clk_out),
		.pad1_in(pad_c_in),
		.pad1_out(pad_c_out),
		.pad1_oe_out(pad_c_oe_out),
		.pad2_in(pad_d_in),
		.pad2_out(pad_d_out),
		.pad2_oe_out(pad_d_oe_out)
	);

	// ==========================================================================
	// checks
	// ==========================================================================
	a_reset_clears_ab: assert property (@(posedge clk_in)
		$fell(rst_in) |-> clock_link_control_reg == acl_pkg::LINK_REG_RESET)
		else $error("core 0 link codes not cleared by reset");
	a_reset_clears_cd: assert property (@(posedge clk_in)
		$fell(rst_in) |-> clock_link_control_reg_core1 == acl_pkg::LINK_REG_RESET)
		else $error("core 1 link codes not cleared by reset");
	a_write_core_split: assert property (@(posedge clk_in) disable iff (rst_in)
		wr_core1 |=> s_axi_bvalid_out && $stable(clock_link_control_reg) &&
			clock_link_control_reg_core1 == $past(next_merged))
		else $error("core 1 write disturbed core 0 or failed");
	a_write_core0: assert property (@(posedge clk_in) disable iff (rst_in)
		wr_core0 |=> s_axi_bvalid_out && $stable(clock_link_control_reg_core1) &&
			clock_link_control_reg == $past(next_merged))
		else $error("core 0 write disturbed core 1 or failed");
	a_field_lanes: assert property (@(posedge clk_in) disable iff (rst_in)
		wr_core0 && w_strb[1:0] == 2'b10 |=>
			clock_link_control_reg[7:0] == $past(clock_link_control_reg[7:0]) &&
			clock_link_control_reg[11:8] == $past(w_data[11:8]))
		else $error("upper code fields not on second byte lane");
	a_reserved_zero: assert property (@(posedge clk_in) disable iff (rst_in)
		s_axi_rvalid_out |-> s_axi_rdata_out[31:12] == 20'h0_0000)
		else $error("reserved bits read nonzero");
	genvar ci;
	generate
		for (ci = 0; ci < acl_pkg::LINK_SIGNALS; ci++) begin : g_chk
			a_unlinked_own: assert property (@(posedge clk_in) disable iff (rst_in)
				!clock_link_control_reg[2*ci+1] |-> pad_b_oe_out[ci] == port_b_dir_in[ci]
					&& port_b_clk_out[ci] == pad_b_in[ci] && port_a_clk_out[ci] == pad_a_in[ci])
				else $error("unlinked port not on its own pin");
			a_ab_code10: assert property (@(posedge clk_in) disable iff (rst_in)
				clock_link_control_reg[2*ci+:2] == 2'b10 |-> pad_a_oe_out[ci] ==
					port_a_dir_in[ci] && port_b_clk_out[ci] == pad_a_in[ci] && !pad_b_oe_out[ci])
				else $error("code 10 routing wrong on A/B");
			a_ab_code11: assert property (@(posedge clk_in) disable iff (rst_in)
				clock_link_control_reg[2*ci+:2] == 2'b11 |-> pad_a_out[ci] ==
					port_b_drive_in[ci] && port_a_clk_out[ci] == pad_a_in[ci])
				else $error("code 11 routing wrong on A/B");
			a_cd_code10: assert property (@(posedge clk_in) disable iff (rst_in)
				clock_link_control_reg_core1[2*ci+:2] == 2'b10 |-> pad_d_oe_out[ci] ==
					port_c_dir_in[ci] && port_d_clk_out[ci] == pad_d_in[ci])
				else $error("code 10 routing wrong on C/D");
			a_cd_code11: assert property (@(posedge clk_in) disable iff (rst_in)
				clock_link_control_reg_core1[2*ci+:2] == 2'b11 |-> pad_d_out[ci] ==
					port_d_drive_in[ci] && port_c_clk_out[ci] == pad_d_in[ci])
				else $error("code 11 routing wrong on C/D");
			a_unlinked_cd: assert property (@(posedge clk_in) disable iff (rst_in)
				!clock_link_control_reg_core1[2*ci+1] |-> pad_c_oe_out[ci] == port_c_dir_in[ci]
					&& port_c_clk_out[ci] == pad_c_in[ci] && port_d_clk_out[ci] == pad_d_in[ci])
				else $error("unlinked C/D port not on its own pin");
			a_cd_idle_pin: assert property (@(posedge clk_in) disable iff (rst_in)
				clock_link_control_reg_core1[2*ci+1] |-> !pad_c_oe_out[ci] &&
					port_c_clk_out[ci] == pad_d_in[ci])
				else $error("linked C/D left port C's pin driven");
			a_ab_owner_b: assert property (@(posedge clk_in) disable iff (rst_in)
				clock_link_control_reg[2*ci+:2] == 2'b11 |-> pad_a_oe_out[ci] ==
					port_b_dir_in[ci] && port_b_clk_out[ci] == pad_a_in[ci] && !pad_b_oe_out[ci])
				else $error("code 11 direction wrong on A/B");
		end
	endgenerate
endmodule // acl_clock_link_top

// ===== core/acl_pkg.sv
/*
 * acl_pkg: shared constants for the audio port clock link block.
 * Assumes: included ahead of every other file of the block; holds no logic.
 */
package acl_pkg;
	// ==========================================================================
	// register map
	// ==========================================================================
	localparam logic [3:0] CORE0_LINK_OFFSET = 4'h0; // link control, core 0, A/B pair
	localparam logic [3:0] CORE1_LINK_OFFSET = 4'h4; // link control, core 1, C/D pair
	localparam int ADDR_W = 4; // byte address bits decoded by the slave
	localparam int DATA_W = 32; // bus data width
	localparam int STRB_W = 4; // bus byte strobes

	// ==========================================================================
	// link code field layout
	// ==========================================================================
	localparam int LINK_SIGNALS = 6; // clocks and frame syncs per port
	localparam int FIELD_W = 2; // bits per link code
	localparam int LINK_REG_W = 12; // implemented bits; everything above is reserved
	localparam int TX_BIT_CLOCK_LINK_LSB = 0; // field at bits 1-0
	localparam int RX_BIT_CLOCK_LINK_LSB = 2; // field at bits 3-2
	localparam int TX_FRAME_SYNC_LINK_LSB = 4; // field at bits 5-4
	localparam int RX_FRAME_SYNC_LINK_LSB = 6; // field at bits 7-6
	localparam int HF_TX_CLOCK_LINK_LSB = 8; // field at bits 9-8
	localparam int HF_RX_CLOCK_LINK_LSB = 10; // field at bits 11-10
	localparam int LINK_ON_BIT = 1; // upper bit of a code: link in use
	localparam int OWNER_BIT = 0; // lower bit: 0 first port owns pin, 1 second

	// ==========================================================================
	// reset values and bus answers
	// ==========================================================================
	localparam logic [11:0] LINK_REG_RESET = 12'h000; // all codes unlinked
	localparam logic [1:0] RESP_OKAY = 2'h0; // normal answer
	localparam logic [1:0] RESP_SLVERR = 2'h2; // unmapped address
endpackage

// ===== core/acl_pair_mux.sv
/*
 * acl_pair_mux: combinational clock routing between one pair of audio ports.
 * Assumes: pad inputs already reflect the resolved pin level, driven or not;
 * the code comes from a register in the caller.
 */
`timescale 1ns/1ps
module acl_pair_mux #(
	parameter bit SHARE_ON_SECOND = 1'b0 // 0: first port's pin is shared, 1: second's
) (
	input wire logic [11:0] code_in, // six two-bit link codes
	input wire logic [5:0] first_drive_in, // first port clock value to drive
	input wire logic [5:0] first_dir_in, // first port wants to drive its pin
	output logic [5:0] first_clk_out, // clock delivered to first port
	input wire logic [5:0] second_drive_in, // second port clock value to drive
	input wire logic [5:0] second_dir_in, // second port wants to drive its pin
	output logic [5:0] second_clk_out, // clock delivered to second port
	input wire logic [5:0] pad1_in, // first port pin level
	output logic [5:0] pad1_out, // first port pin drive value
	output logic [5:0] pad1_oe_out, // first port pin enable
	input wire logic [5:0] pad2_in, // second port pin level
	output logic [5:0] pad2_out, // second port pin drive value
	output logic [5:0] pad2_oe_out // second port pin enable
);
	// ==========================================================================
	// per signal routing
	// ==========================================================================
	// pure gates, so a routed clock sees no register stage
	genvar gi;
	generate
		for (gi = 0; gi < acl_pkg::LINK_SIGNALS; gi++) begin : g_sig
			logic link_on; // code upper bit set
			logic second_owns; // code lower bit: owner of the shared pin
			logic own_drive; // value from whichever port owns the shared pin
			logic own_dir; // direction from the owner
			logic shared_lvl; // level on the shared pin
			assign link_on = code_in[gi*acl_pkg::FIELD_W + acl_pkg::LINK_ON_BIT];
			assign second_owns = code_in[gi*acl_pkg::FIELD_W + acl_pkg::OWNER_BIT];
			assign own_drive = second_owns ? second_drive_in[gi] : first_drive_in[gi];
			assign own_dir = second_owns ? second_dir_in[gi] : first_dir_in[gi];
			assign shared_lvl = SHARE_ON_SECOND ? pad2_in[gi] : pad1_in[gi];
			always_comb begin
				if (!link_on) begin
					// each port on its own pin, codes 00 and 01 alike
					pad1_out[gi] = first_drive_in[gi];
					pad1_oe_out[gi] = first_dir_in[gi];
					pad2_out[gi] = second_drive_in[gi];
					pad2_oe_out[gi] = second_dir_in[gi];
					first_clk_out[gi] = pad1_in[gi];
					second_clk_out[gi] = pad2_in[gi];
				end else begin
					// owner steers the shared pin; the idle pin is released so the
					// partner cannot fight it
					pad1_out[gi] = SHARE_ON_SECOND ? 1'b0 : own_drive;
					pad1_oe_out[gi] = SHARE_ON_SECOND ? 1'b0 : own_dir;
					pad2_out[gi] = SHARE_ON_SECOND ? own_drive : 1'b0;
					pad2_oe_out[gi] = SHARE_ON_SECOND ? own_dir : 1'b0;
					// both ports hear the shared pin whatever its direction
					first_clk_out[gi] = shared_lvl;
					second_clk_out[gi] = shared_lvl;
				end
			end
		end
	endgenerate
endmodule // acl_pair_mux

// ===== test/acl_pad_model.sv
/*
 * acl_pad_model: the four audio ports' clock pins, seen from the board.
 * Assumes: enable high means the block drives the pin; when it does not,
 * an outside device drives it with a level the bench changes every check.
 */
`timescale 1ns/1ps
module acl_pad_model (
	input wire logic [23:0] drv_in, // pin drive values, port a in bits 5:0
	input wire logic [23:0] oe_in, // pin enables, high while the block drives
	input wire logic [23:0] ext_in, // outside device level on released pins
	output logic [23:0] lvl_out // resolved pin levels back into the block
);
	// ==========================================================================
	// pin resolution
	// ==========================================================================
	// a released pin shows the outside device, never the last driven value,
	// so a stuck enable cannot hide behind a held level
	// no pin switch is modelled, so a link never meets a swapped pin
	assign lvl_out = (oe_in & drv_in) | (~oe_in & ext_in);
endmodule // acl_pad_model

// ===== test/acl_clock_link_top_tb.sv
/*
 * acl_clock_link_top_tb: self-checking bench for the clock link block.
 * Assumes: acl_pkg, the design and the pad model are compiled first.
 */
`timescale 1ns/1ps
module acl_clock_link_top_tb;
	// ==========================================================================
	// clock, reset, bus and port signals
	// ==========================================================================
	logic clk_in = 1'b0; // 40 MHz system clock
	logic rst_in = 1'b1; // asynchronous reset, held at start
	logic [3:0] awaddr = '0, araddr = '0; // bus addresses
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [31:0] wdata = '0; // write data
	logic [3:0] wstrb = '0; // write strobes
	wire awready, wready, bvalid, arready, rvalid;
	wire [1:0] bresp, rresp;
	wire [31:0] rdata;
	logic [3:0][5:0] drv = '0, dir = '0; // port clock values and directions
	logic [23:0] ext = '0; // outside device levels
	wire [3:0][5:0] clko, po, poe, lvl; // clocks into ports, pin drive, pin enables, pin levels
	logic rt_chk = 1'b0; // routing sample strobe
	logic [33:0] rd_q [$]; // expected {rresp, rdata}
	logic [1:0] wr_q [$]; // expected bresp
	logic [71:0] rt_q [$]; // expected {clocks, pin drive, pin enables}
	logic [11:0] shadow [2] = '{12'h000, 12'h000}; // expected register contents
	int failures = 0;
	int comparisons = 0;

	always #12.5 clk_in = ~clk_in;

	acl_clock_link_top dut (.clk_in(clk_in), .rst_in(rst_in),
		.s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
		.s_axi_wdata_in(wdata), .s_axi_wstrb_in(wstrb), .s_axi_wvalid_in(wvalid),
		.s_axi_wready_out(wready), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid),
		.s_axi_bready_in(bready), .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
		.s_axi_arready_out(arready), .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp),
		.s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready),
		.port_a_drive_in(drv[0]), .port_a_dir_in(dir[0]), .port_a_clk_out(clko[0]),
		.port_b_drive_in(drv[1]), .port_b_dir_in(dir[1]), .port_b_clk_out(clko[1]),
		.port_c_drive_in(drv[2]), .port_c_dir_in(dir[2]), .port_c_clk_out(clko[2]),
		.port_d_drive_in(drv[3]), .port_d_dir_in(dir[3]), .port_d_clk_out(clko[3]),
		.pad_a_in(lvl[0]), .pad_a_out(po[0]), .pad_a_oe_out(poe[0]),
		.pad_b_in(lvl[1]), .pad_b_out(po[1]), .pad_b_oe_out(poe[1]),
		.pad_c_in(lvl[2]), .pad_c_out(po[2]), .pad_c_oe_out(poe[2]),
		.pad_d_in(lvl[3]), .pad_d_out(po[3]), .pad_d_oe_out(poe[3]));

	acl_pad_model pads (.drv_in(po), .oe_in(poe), .ext_in(ext), .lvl_out(lvl));

	// ==========================================================================
	// comparison, verdict and timeout
	// ==========================================================================
	task automatic check(input string name, input logic [71:0] seen, input logic [71:0] exp);
		comparisons++;
		if (seen !== exp) begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic complete_run();
		if (failures == 0 && comparisons > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	task automatic timeout();
		failures++;
		complete_run();
	endtask

	// ==========================================================================
	// watchers: take the oldest note whenever a result shows
	// ==========================================================================
	always @(posedge clk_in) begin
		if (!rst_in && bvalid && bready) begin
			check("write response", bresp, wr_q.pop_front());
		end
		if (!rst_in && rvalid && rready) begin
			check("read data", {rresp, rdata}, rd_q.pop_front());
		end
	end

	// sampled half a cycle after the inputs change: any register stage shows as a lag
	always @(negedge clk_in) begin
		if (rt_chk) begin
			check("routing", {clko, po & poe, poe}, rt_q.pop_front());
		end
	end

	// ==========================================================================
	// bus master tasks: hold each channel until its own ready
	// ==========================================================================
	task automatic axi_write(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s,
		input logic [1:0] r);
		bit ad, wd;
		int n;
		ad = 1'b0;
		wd = 1'b0;
		@(posedge clk_in);
		wr_q.push_back(r);
		awaddr <= a;
		wdata <= d;
		wstrb <= s;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (n = 0; n < 40 && !(ad && wd); n++) begin
			@(posedge clk_in);
			if (!ad && awready) begin
				ad = 1'b1;
				awvalid <= 1'b0;
			end
			if (!wd && wready) begin
				wd = 1'b1;
				wvalid <= 1'b0;
			end
		end
		if (!(ad && wd)) timeout();
		for (n = 0; n < 40; n++) begin
			@(posedge clk_in);
			if (bvalid) break;
		end
		if (n == 40) timeout();
		bready <= 1'b0;
	endtask

	task automatic axi_read(input logic [3:0] a, input logic [33:0] e);
		int n;
		@(posedge clk_in);
		rd_q.push_back(e);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (n = 0; n < 40; n++) begin
			@(posedge clk_in);
			if (arready) break;
		end
		if (n == 40) timeout();
		arvalid <= 1'b0;
		for (n = 0; n < 40; n++) begin
			@(posedge clk_in);
			if (rvalid) break;
		end
		if (n == 40) timeout();
		rready <= 1'b0;
	endtask

	// ==========================================================================
	// routing: random port and pin activity, expectation per signal
	// ==========================================================================
	task automatic route_check();
		logic [3:0][5:0] e, d, x, eo, ed, ec;
		logic [1:0] c;
		int f, s, sh, ot, own;
		@(posedge clk_in);
		d = 24'($urandom);
		e = 24'($urandom);
		x = 24'($urandom);
		for (int p = 0; p < 2; p++) begin
			for (int i = 0; i < 6; i++) begin
				f = 2 * p;
				s = f + 1;
				sh = p ? s : f; // shared pin: a for the first pair, d for the second
				ot = p ? f : s;
				c = shadow[p][2 * i +: 2];
				if (c[1]) begin
					e[c[0] ? f : s][i] = 1'b0; // non-owner set as input
					own = c[0] ? s : f;
					eo[sh][i] = e[own][i];
					ed[sh][i] = d[own][i];
					eo[ot][i] = 1'b0;
					ed[ot][i] = 1'b0;
					ec[f][i] = eo[sh][i] ? ed[sh][i] : x[sh][i];
					ec[s][i] = ec[f][i];
				end else begin
					eo[f][i] = e[f][i];
					ed[f][i] = d[f][i];
					eo[s][i] = e[s][i];
					ed[s][i] = d[s][i];
					ec[f][i] = e[f][i] ? d[f][i] : x[f][i];
					ec[s][i] = e[s][i] ? d[s][i] : x[s][i];
				end
			end
		end
		drv <= d;
		dir <= e;
		ext <= x;
		rt_q.push_back({ec, ed & eo, eo});
		rt_chk <= 1'b1;
		@(posedge clk_in);
		rt_chk <= 1'b0;
	endtask

	// ==========================================================================
	// main sequence
	// ==========================================================================
	initial begin
		int p;
		logic [31:0] d;
		logic [3:0] s, a;
		void'($urandom(32'h51ac));
		repeat (8) @(posedge clk_in);
		rst_in <= 1'b0;
		axi_read(acl_pkg::CORE0_LINK_OFFSET, '0);
		axi_read(acl_pkg::CORE1_LINK_OFFSET, '0);
		route_check();
		// unmapped places refuse without touching either register
		axi_read(4'h8, {acl_pkg::RESP_SLVERR, 32'h0000_0000});
		axi_write(4'hc, 32'hffff_ffff, 4'hf, acl_pkg::RESP_SLVERR);
		// first eight: every code on every field of both pairs, then random
		for (int k = 0; k < 48; k++) begin
			p = k % 2;
			a = p ? acl_pkg::CORE1_LINK_OFFSET : acl_pkg::CORE0_LINK_OFFSET;
			d = (k < 8) ? {16{k[2:1]}} : $urandom;
			s = (k < 8) ? 4'hf : 4'($urandom);
			if (s[0]) shadow[p][7:0] = d[7:0];
			if (s[1]) shadow[p][11:8] = d[11:8];
			axi_write(a, d, s, acl_pkg::RESP_OKAY);
			axi_read(a, {acl_pkg::RESP_OKAY, 20'h0_0000, shadow[p]});
			route_check();
		end
		// reset in mid-run clears both pairs back to unlinked routing
		@(posedge clk_in);
		rst_in <= 1'b1;
		@(posedge clk_in);
		rst_in <= 1'b0;
		shadow = '{12'h000, 12'h000};
		axi_read(acl_pkg::CORE0_LINK_OFFSET, '0);
		axi_read(acl_pkg::CORE1_LINK_OFFSET, '0);
		route_check();
		complete_run();
	end
endmodule // acl_clock_link_top_tb
